/* hw/ivd_interrupt_vector_dispatch.sv */
`timescale 1ns/10ps
module ivd_interrupt_vector_dispatch (
    input  wire logic                                clk,
    input  wire logic                                rst_n,
    input  wire logic [ivd_pkg::N_EXT-1:0]           externalIrq,
    input  wire logic [ivd_pkg::N_EXT-1:0]           extEdgeMode,
    input  wire logic                                serialTxIrq,
    input  wire logic                                serialRxIrq,
    input  wire logic                                timerIrq0,
    input  wire logic                                timerIrq1,
    input  wire logic                                dmaIrq0,
    input  wire logic                                dmaIrq1,
    input  wire logic [ivd_pkg::N_SRC-1:0]           irqEnable,
    input  wire logic                                baseWrite,
    input  wire logic [ivd_pkg::ADDR_W-1:0]          baseData,
    input  wire logic                                trapReq,
    input  wire logic [4:0]                          trapNum,
    input  wire logic                                vectorAck,
    input  wire logic                                sleepReq,
    output logic                                     vectorValid,
    output logic [ivd_pkg::ADDR_W-1:0]               vectorAddr,
    output logic [ivd_pkg::SLOT_W-1:0]               vectorSlot,
    output logic                                     sleeping,
    output logic                                     clkPhase1,
    output logic                                     clkPhase3
);
    ivd_pkg::ivd_state_t            state_q;
    logic [ivd_pkg::ADDR_W-1:0]     base_q;
    logic [ivd_pkg::N_EXT-1:0]      extPrev_q;
    logic [ivd_pkg::N_SRC-1:0]      pend_q;
    logic [ivd_pkg::N_SRC-1:0]      srcLevel;
    logic [ivd_pkg::N_SRC-1:0]      setEvt;
    logic [ivd_pkg::N_SRC-1:0]      clrEvt;
    logic [ivd_pkg::N_SRC-1:0]      ready;
    logic [ivd_pkg::SLOT_W-1:0]     pickSlot;
    logic [ivd_pkg::N_SRC-1:0]      pickBit;
    logic                           pickAny;
    logic [ivd_pkg::SLOT_W-1:0]     srcSlot [ivd_pkg::N_SRC];
    logic [ivd_pkg::SLOT_W-1:0]     trapSlot;
    logic                           canIssue;
    logic                           issueIrq;
    logic                           issueTrap;
    logic                           sleepOk;
    logic                           wakeEvt;
    logic                           phaseRun;

    // slot of each request source, in table order
    function automatic logic [ivd_pkg::SLOT_W-1:0] slotOf(input int src);
        logic [ivd_pkg::SLOT_W-1:0] slot;
        slot = ivd_pkg::SLOT_EXT0 + ivd_pkg::SLOT_W'(src);
        case (src)
            ivd_pkg::SRC_SER_TX: slot = ivd_pkg::SLOT_SER_TX;
            ivd_pkg::SRC_SER_RX: slot = ivd_pkg::SLOT_SER_RX;
            ivd_pkg::SRC_TIMER0: slot = ivd_pkg::SLOT_TIMER0;
            ivd_pkg::SRC_TIMER1: slot = ivd_pkg::SLOT_TIMER1;
            ivd_pkg::SRC_DMA0:   slot = ivd_pkg::SLOT_DMA0;
            ivd_pkg::SRC_DMA1:   slot = ivd_pkg::SLOT_DMA1;
            default: ;
        endcase
        return slot;
    endfunction

    assign srcLevel = {dmaIrq1, dmaIrq0, timerIrq1, timerIrq0, serialRxIrq, serialTxIrq, externalIrq};

    genvar g;
    generate
        for (g = 0; g < ivd_pkg::N_SRC; g++) begin : gSlot
            assign srcSlot[g] = slotOf(g);
        end

        for (g = 0; g < ivd_pkg::N_EXT; g++) begin : gExt
            // edge lines latch a rising edge; level lines follow the pin
            assign setEvt[g] = extEdgeMode[g] ? (externalIrq[g] & ~extPrev_q[g]) : externalIrq[g];
        end

        // peripheral requests are levels: pending is set each cycle they stand
        for (g = ivd_pkg::N_EXT; g < ivd_pkg::N_SRC; g++) begin : gInt
            assign setEvt[g] = srcLevel[g];
        end
    endgenerate

    assign ready = pend_q & irqEnable;

    // lowest slot wins, so external lines outrank peripherals
    always_comb begin
        pickAny  = 1'b0;
        pickSlot = '0;
        pickBit  = '0;
        for (int i = 0; i < ivd_pkg::N_SRC; i++) begin
            if (ready[i] && !pickAny) begin
                pickAny    = 1'b1;
                pickSlot   = srcSlot[i];
                pickBit[i] = 1'b1;
            end
        end
    end

    // both kinds of request wait until the vector on show is taken
    assign canIssue  = (state_q == ivd_pkg::IVD_RUN) && (!vectorValid || vectorAck);
    assign issueIrq  = canIssue && !trapReq && pickAny;
    assign issueTrap = canIssue && trapReq;
    assign trapSlot  = ivd_pkg::SLOT_SOFTWARE_TRAP_FIRST + ivd_pkg::SLOT_W'(trapNum);
    assign sleepOk   = sleepReq && !vectorValid && !pickAny && !trapReq;
    assign wakeEvt   = |externalIrq;
    assign phaseRun  = (state_q != ivd_pkg::IVD_SLEEP);
    assign clrEvt    = issueIrq ? pickBit : '0;

    // history resets to the idle pin level, so no false edge follows reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            extPrev_q <= '0;
        end else begin
            extPrev_q <= externalIrq;
        end
    end

    // a new event in the taking cycle keeps the flag set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~clrEvt) | setEvt;
        end
    end

    // low bits forced zero: a misaligned write cannot break the base-plus-slot sum
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            base_q <= ivd_pkg::BASE_RESET;
        end else if (baseWrite) begin
            base_q <= {baseData[ivd_pkg::ADDR_W-1:ivd_pkg::ALIGN_W], {ivd_pkg::ALIGN_W{1'b0}}};
        end
    end

    // nothing issues until the consumer has taken the reset vector
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ivd_pkg::IVD_RESET_FETCH;
        end else begin
            unique case (state_q)
                ivd_pkg::IVD_RESET_FETCH: begin
                    if (vectorAck) begin
                        state_q <= ivd_pkg::IVD_RUN;
                    end
                end
                ivd_pkg::IVD_RUN: begin
                    if (sleepOk) begin
                        state_q <= ivd_pkg::IVD_SLEEP;
                    end
                end
                ivd_pkg::IVD_SLEEP: begin
                    if (wakeEvt) begin
                        state_q <= ivd_pkg::IVD_RUN;
                    end
                end
                default: state_q <= ivd_pkg::IVD_RUN;
            endcase
        end
    end

    // reset vector stands straight out of reset, before any base is written
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vectorValid <= 1'b1;
        end else if (issueTrap || issueIrq) begin
            vectorValid <= 1'b1;
        end else if (vectorAck) begin
            vectorValid <= 1'b0;
        end
    end

    // traps outrank interrupts when both are ready
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vectorSlot <= '0;
        end else if (issueTrap) begin
            vectorSlot <= trapSlot;
        end else if (issueIrq) begin
            vectorSlot <= pickSlot;
        end
    end

    // base is applied only at issue, so a base write never moves a vector on show
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vectorAddr <= ivd_pkg::RESET_VECTOR;
        end else if (issueTrap) begin
            vectorAddr <= base_q + ivd_pkg::ADDR_W'(trapSlot);
        end else if (issueIrq) begin
            vectorAddr <= base_q + ivd_pkg::ADDR_W'(pickSlot);
        end
    end

    // sleeping trails the state by one clock, like the frozen phases
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleeping <= 1'b0;
        end else begin
            sleeping <= !phaseRun;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clkPhase1 <= 1'b1;
        end else if (!phaseRun) begin
            clkPhase1 <= 1'b1;
        end else begin
            clkPhase1 <= ~clkPhase1;
        end
    end

    // phase 3 trails phase 1 by one clock; held low in deep sleep
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clkPhase3 <= 1'b0;
        end else if (!phaseRun) begin
            clkPhase3 <= 1'b0;
        end else begin
            clkPhase3 <= clkPhase1;
        end
    end
endmodule

/* include/ivd_pkg.sv */
package ivd_pkg;
    localparam int ADDR_W      = 24;
    localparam int ALIGN_W     = 8;
    localparam int SLOT_W      = 6;
    localparam int N_EXT       = 4;
    localparam int N_SRC       = 10;
    localparam int N_TRAP      = 32;
    localparam logic [ADDR_W-1:0] RESET_VECTOR = 24'h000000;
    localparam logic [ADDR_W-1:0] BASE_RESET   = 24'h000000;
    // slot indices within the table
    localparam logic [SLOT_W-1:0] SLOT_EXT0    = 6'h01;
    localparam logic [SLOT_W-1:0] SLOT_SER_TX  = 6'h05;
    localparam logic [SLOT_W-1:0] SLOT_SER_RX  = 6'h06;
    localparam logic [SLOT_W-1:0] SLOT_TIMER0  = 6'h09;
    localparam logic [SLOT_W-1:0] SLOT_TIMER1  = 6'h0a;
    localparam logic [SLOT_W-1:0] SLOT_DMA0    = 6'h0b;
    localparam logic [SLOT_W-1:0] SLOT_DMA1    = 6'h0c;
    localparam logic [SLOT_W-1:0] SLOT_SOFTWARE_TRAP_FIRST   = 6'h20;
    // source bit positions in the pending vector
    localparam int SRC_SER_TX = 4;
    localparam int SRC_SER_RX = 5;
    localparam int SRC_TIMER0 = 6;
    localparam int SRC_TIMER1 = 7;
    localparam int SRC_DMA0   = 8;
    localparam int SRC_DMA1   = 9;
    typedef enum logic [1:0] {IVD_RESET_FETCH, IVD_RUN, IVD_SLEEP} ivd_state_t;
endpackage

/* testbench/ivd_src_model.sv */
`timescale 1ns/10ps
module ivd_src_model (
    input  wire logic       clk,
    output logic      [9:0] src
);
    initial src = 10'h000;
    // held whole cycles so every request meets an edge
    task automatic raise(input int i, input int n);
        @(posedge clk) src[i] <= 1'b1;
        repeat (n) @(posedge clk);
        src[i] <= 1'b0;
    endtask
endmodule

/* testbench/ivd_sva.sv */
`timescale 1ns/10ps
module ivd_sva (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [3:0]  externalIrq,
    input wire logic        vectorAck,
    input wire logic        vectorValid,
    input wire logic [23:0] vectorAddr,
    input wire logic [5:0]  vectorSlot,
    input wire logic        sleeping,
    input wire logic        clkPhase1,
    input wire logic        clkPhase3
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_reset_vec;
        !$past(rst_n) |-> vectorValid && vectorAddr == 24'h000000;
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("reset vector off zero");
    property p_offset;
        vectorValid |-> vectorAddr[7:0] == {2'h0, vectorSlot};
    endproperty
    a_offset: assert property (p_offset) else $error("address not base plus slot");
    property p_slot;
        vectorValid |-> vectorSlot inside {[0:6], [9:12], [32:63]};
    endproperty
    a_slot: assert property (p_slot) else $error("reserved slot issued");
    property p_hold;
        vectorValid && !vectorAck |=> vectorValid && $stable(vectorAddr);
    endproperty
    a_hold: assert property (p_hold) else $error("vector dropped before ack");
    property p_still;
        sleeping && !$past(|externalIrq) && !$past(|externalIrq, 2) |-> clkPhase1 && !clkPhase3;
    endproperty
    a_still: assert property (p_still) else $error("phases move in sleep");
    property p_wake;
        sleeping && |externalIrq |-> ##[1:3] !sleeping;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on external request");
endmodule
bind ivd_interrupt_vector_dispatch ivd_sva u_sva (
    .clk         (clk),
    .rst_n       (rst_n),
    .externalIrq (externalIrq),
    .vectorAck   (vectorAck),
    .vectorValid (vectorValid),
    .vectorAddr  (vectorAddr),
    .vectorSlot  (vectorSlot),
    .sleeping    (sleeping),
    .clkPhase1   (clkPhase1),
    .clkPhase3   (clkPhase3)
);

/* testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic        clk = 1'b0, rst_n = 1'b0, baseWrite = 1'b0, trapReq = 1'b0, vectorAck = 1'b0, sleepReq = 1'b0;
    logic        serialTxIrq, serialRxIrq, timerIrq0, timerIrq1, dmaIrq0, dmaIrq1, vectorValid, sleeping;
    logic        clkPhase1, clkPhase3;
    logic [3:0]  externalIrq, extEdgeMode = 4'hf;
    logic [9:0]  irqEnable = 10'h3ff, src;
    logic [23:0] baseData = 24'h000000, vectorAddr;
    logic [4:0]  trapNum = 5'h00;
    logic [5:0]  vectorSlot;
    int          n_errors = 0, checks = 0;
    ivd_interrupt_vector_dispatch uut (
        .clk         (clk),
        .rst_n       (rst_n),
        .externalIrq (externalIrq),
        .extEdgeMode (extEdgeMode),
        .serialTxIrq (serialTxIrq),
        .serialRxIrq (serialRxIrq),
        .timerIrq0   (timerIrq0),
        .timerIrq1   (timerIrq1),
        .dmaIrq0     (dmaIrq0),
        .dmaIrq1     (dmaIrq1),
        .irqEnable   (irqEnable),
        .baseWrite   (baseWrite),
        .baseData    (baseData),
        .trapReq     (trapReq),
        .trapNum     (trapNum),
        .vectorAck   (vectorAck),
        .sleepReq    (sleepReq),
        .vectorValid (vectorValid),
        .vectorAddr  (vectorAddr),
        .vectorSlot  (vectorSlot),
        .sleeping    (sleeping),
        .clkPhase1   (clkPhase1),
        .clkPhase3   (clkPhase3)
    );
    ivd_src_model src_i (.clk(clk), .src(src));
    assign {dmaIrq1, dmaIrq0, timerIrq1, timerIrq0, serialRxIrq, serialTxIrq, externalIrq} = src;
    initial forever #4 clk = ~clk;
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // looks at falling edges, where the registered outputs have settled
    task wt(input logic s, input logic v);
        int k;
        @(negedge clk);
        for (k = 0; k < 64 && (s ? sleeping : vectorValid) !== v; k++) @(negedge clk);
        if ((s ? sleeping : vectorValid) !== v) begin
            n_errors++;
            conclude;
        end
    endtask
    // waits a settle point first: a back-to-back vector must not be mistaken for the old one
    task expv(input logic [23:0] a);
        wt(1'b0, 1'b1);
        chk(vectorAddr, a);
        chk({18'h0, vectorSlot}, {18'h0, a[5:0]});
        @(posedge clk);
        trapReq   <= 1'b0;
        vectorAck <= 1'b1;
        @(posedge clk);
        vectorAck <= 1'b0;
    endtask
    task t_reset(input int n);
        @(posedge clk) rst_n <= 1'b0;
        repeat (n) @(posedge clk);
        rst_n <= 1'b1;
        expv(24'h000000);
        $display("reset done");
    endtask
    task t_map;
        int i;
        logic [5:0] slots [10] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h09, 6'h0a, 6'h0b, 6'h0c};
        @(posedge clk) baseWrite <= 1'b1;
        baseData <= 24'h456700;
        @(posedge clk) baseWrite <= 1'b0;
        for (i = 0; i < 10; i++) begin
            src_i.raise(i, 1);
            expv(24'h456700 + {18'h0, slots[i]});
        end
        for (i = 0; i < 32; i++) begin
            @(posedge clk) trapReq <= 1'b1;
            trapNum <= 5'(i);
            expv(24'h456720 + 24'(i));
        end
        $display("map done");
    endtask
    task t_level;
        src_i.raise(1, 4);
        expv(24'h456702);
        wt(1'b0, 1'b0);
        @(posedge clk) extEdgeMode <= 4'hd;
        src_i.raise(1, 4);
        expv(24'h456702);
        expv(24'h456702);
        wt(1'b0, 1'b0);
        $display("level done");
    endtask
    // a disabled source stays pending and issues once enabled
    task t_mask;
        @(posedge clk) irqEnable <= 10'h3bf;
        src_i.raise(6, 1);
        repeat (4) @(negedge clk);
        chk({23'h0, vectorValid}, 24'h000000);
        @(posedge clk) irqEnable <= 10'h3ff;
        expv(24'h456709);
        $display("mask done");
    endtask
    task t_sleep;
        @(posedge clk) sleepReq <= 1'b1;
        wt(1'b1, 1'b1);
        repeat (3) @(negedge clk);
        chk({22'h0, clkPhase1, clkPhase3}, 24'h000002);
        src_i.raise(0, 1);
        sleepReq <= 1'b0;
        wt(1'b1, 1'b0);
        expv(24'h456701);
        $display("sleep done");
    endtask
    initial begin
        t_reset(5);
        t_map;
        t_level;
        t_mask;
        t_sleep;
        t_reset(2);
        conclude;
    end
endmodule
